//--- rtl/sms_pkg.sv
// shared constants and types for the sar measurement sequencer
// assumes one 100 mhz clock and a decoded register port in front of the block
package sms_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] SMS_CONV_CTRL   = 8'h00;
	localparam logic [7:0] SMS_TOUCH_CFG   = 8'h01;
	localparam logic [7:0] SMS_AUTO_CTRL   = 8'h0c;
	localparam logic [7:0] SMS_THR_MIN     = 8'h0d;
	localparam logic [7:0] SMS_THR_MAX     = 8'h0e;
	localparam logic [7:0] SMS_RESULT_BASE = 8'h10;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SMS_SCAN_LSB     = 10;
	localparam int SMS_MODE_BIT     = 12;
	localparam int SMS_PEN_LSB      = 14;
	localparam int SMS_TEMP_EN_BIT  = 15;
	localparam int SMS_AUX_EN_BIT   = 14;
	localparam int SMS_RANGE_BIT    = 13;
	localparam int SMS_PULSE_EN_BIT = 9;
	localparam int SMS_IVL_LSB      = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] SMS_CONV_RST = 16'h0000;
	localparam logic [15:0] SMS_CFG_RST  = 16'h0000;
	localparam logic [15:0] SMS_AUTO_RST = 16'h0000;
	localparam logic [11:0] SMS_MIN_RST  = 12'h000;
	localparam logic [11:0] SMS_MAX_RST  = 12'hfff;

	// ****************************************
	// timing
	// ****************************************
	localparam int SMS_CLK_MHZ    = 100;
	localparam int SMS_SETTLE_US  = 10;
	localparam int SMS_SETTLE_CYC = SMS_SETTLE_US * SMS_CLK_MHZ;
	localparam int SMS_SAMPLE_NS  = 500;
	localparam int SMS_SAMPLE_CYC = (SMS_SAMPLE_NS * SMS_CLK_MHZ + 999) / 1000;
	localparam int SMS_PULSE_MS   = 2;
	localparam int SMS_PULSE_CYC  = SMS_PULSE_MS * 1000 * SMS_CLK_MHZ;
	localparam int SMS_TICK_US    = 100;
	localparam int SMS_TICK_CYC   = SMS_TICK_US * SMS_CLK_MHZ;
	localparam int SMS_NSRC       = 9;

	// scan function codes held in the scan select field
	typedef enum logic [3:0] {
		SCAN_NONE = 4'h0, SCAN_XY = 4'h1, SCAN_XYZ = 4'h2, SCAN_X = 4'h3,
		SCAN_Y = 4'h4, SCAN_BAT = 4'h5, SCAN_AUX_INPUT_ONE = 4'h6, SCAN_AUX_INPUT_TWO = 4'h7,
		SCAN_AUX_CONT = 4'h8, SCAN_TEMP = 4'h9, SCAN_TDIFF = 4'ha,
		SCAN_PORT = 4'hb, SCAN_RES_EXT = 4'hc, SCAN_RES_INT = 4'hd,
		SCAN_DRV_X = 4'he, SCAN_DRV_Y = 4'hf
	} sms_scan_t;

	// converter input select, also the result index
	typedef enum logic [3:0] {
		SRC_X = 4'h0, SRC_Y = 4'h1, SRC_Z1 = 4'h2, SRC_Z2 = 4'h3,
		SRC_BAT = 4'h4, SRC_AUX_INPUT_ONE = 4'h5, SRC_AUX_INPUT_TWO = 4'h6,
		SRC_TEMP_BASE_CURRENT_RESULT = 4'h7, SRC_TEMP_RAISED_CURRENT_RESULT = 4'h8
	} sms_src_t;

	typedef struct packed {
		logic x_drv;
		logic y_drv;
		logic bat_div;
		logic temp_hi;
		logic res_int;
		logic res_ext;
	} sms_drive_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} sms_reg_req_t;
endpackage

//--- rtl/sms_timer.sv
// loadable down counter used for settling, interval and pulse timing
// assumes load and count come from logic on the same clock
`timescale 1ns/1ns
module sms_timer #(
	parameter int W = 16
) (
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] count_i,
	output logic              busy_o,
	output logic              expire_o
);
	logic [W-1:0] cnt;

	// a load always wins so a restart is never lost
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= '0;
		end else if (load_i) begin
			cnt <= count_i;
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	assign busy_o   = (cnt != '0);
	assign expire_o = (cnt == W'(1));
endmodule

//--- rtl/sms_sequencer.sv
// host- and interval-initiated measurement sequencer for the touch-screen sar converter
// assumes a decoded register port and a sar core on the same clock
`timescale 1ns/1ns
module sms_sequencer
	import sms_pkg::*;
#(
	parameter int PULSE_CYC = SMS_PULSE_CYC,
	parameter int TICK_CYC  = SMS_TICK_CYC
) (
	input  wire logic          clock_i,
	input  wire logic          rst_i,
	input  wire sms_reg_req_t  reg_req_i,
	output logic [15:0]        reg_rdata_o,
	input  wire logic          touch_detect_i,
	output logic               conv_start_o,
	output sms_src_t           conv_sel_o,
	input  wire logic          conv_done_i,
	input  wire logic [11:0]   conv_data_i,
	output sms_drive_t         drive_o,
	output logic               pen_data_ready_line_n_o,
	output logic               general_pin_one_o
);
	localparam int PULSE_W = $clog2(PULSE_CYC + 1);
	localparam int IVL_W   = 24;

	// ****************************************
	// elaboration checks
	// ****************************************
	if (PULSE_CYC < 1 || TICK_CYC < 1 || TICK_CYC * 256 >= 2 ** IVL_W) begin : g_chk
		$error("timing parameter out of range");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_SAMPLE, ST_CONVERT} sms_st_t;

	// ****************************************
	// sequencing helpers
	// ****************************************
	function automatic sms_src_t step_src(sms_scan_t op, logic [1:0] idx);
		sms_src_t s;
		s = SRC_AUX_INPUT_ONE;
		unique case (op)
			SCAN_XY, SCAN_XYZ: s = sms_src_t'({2'b00, idx});
			SCAN_X, SCAN_DRV_X, SCAN_NONE: s = SRC_X;
			SCAN_Y, SCAN_DRV_Y: s = SRC_Y;
			SCAN_BAT: s = SRC_BAT;
			SCAN_AUX_INPUT_ONE, SCAN_AUX_CONT, SCAN_RES_EXT, SCAN_RES_INT: s = SRC_AUX_INPUT_ONE;
			SCAN_AUX_INPUT_TWO: s = SRC_AUX_INPUT_TWO;
			SCAN_TEMP: s = SRC_TEMP_BASE_CURRENT_RESULT;
			SCAN_TDIFF: s = (idx == 2'd0) ? SRC_TEMP_BASE_CURRENT_RESULT : SRC_TEMP_RAISED_CURRENT_RESULT;
			SCAN_PORT: s = sms_src_t'(4'(SRC_BAT) + {2'b00, idx});
		endcase
		return s;
	endfunction

	function automatic logic [1:0] step_last(sms_scan_t op);
		unique case (op)
			SCAN_XYZ: return 2'd3;
			SCAN_PORT: return 2'd2;
			SCAN_XY, SCAN_TDIFF: return 2'd1;
			default: return 2'd0;
		endcase
	endfunction

	function automatic logic is_touch(sms_scan_t op);
		return op inside {SCAN_XY, SCAN_XYZ, SCAN_X, SCAN_Y};
	endfunction

	// ****************************************
	// state
	// ****************************************
	sms_st_t    state;
	sms_st_t    next_state;
	logic [15:0] conv_ctrl;
	logic [15:0] touch_cfg;
	logic [15:0] auto_cfg;
	logic [11:0] thr_min;
	logic [11:0] thr_max;
	logic        range_flag;
	logic [11:0] results [SMS_NSRC];
	logic [11:0] stage [SMS_NSRC];
	logic [SMS_NSRC-1:0] written;
	logic [SMS_NSRC-1:0] unread;
	logic [SMS_NSRC-1:0] next_written;
	sms_scan_t  op;
	logic [1:0] idx;
	logic       auto_run;
	logic       auto_turn;
	logic       start_pend;
	logic       auto_pend;
	logic       hold_x;
	logic       hold_y;
	logic       touch_m;
	logic       touch_s;
	logic       touch_q;
	logic       both_low;

	logic       tmr_load;
	logic [15:0] tmr_count;
	logic       tmr_expire;
	logic       ivl_busy;
	logic       ivl_expire;
	logic       pulse_busy;

	// ****************************************
	// decode
	// ****************************************
	sms_scan_t wr_scan;
	sms_src_t  cur_src;
	logic      host_mode;
	logic      conv_wr;
	logic      legal;
	logic      last_step;
	logic      finish;
	logic      range_evt;
	logic      flag_rd;
	logic      auto_any;
	logic      res_rd;
	logic [3:0] res_idx;

	assign wr_scan   = sms_scan_t'(reg_req_i.wdata[SMS_SCAN_LSB +: 4]);
	assign host_mode = touch_cfg[SMS_MODE_BIT];
	assign conv_wr   = reg_req_i.wr && reg_req_i.addr == SMS_CONV_CTRL;
	// port scan host only
	// nontouch scans are refused unless the converter is host-controlled
	assign legal = conv_wr && wr_scan != SCAN_NONE
		&& !(wr_scan inside {SCAN_DRV_X, SCAN_DRV_Y})
		&& (is_touch(wr_scan) || host_mode);
	assign cur_src   = step_src(op, idx);
	assign last_step = idx == step_last(op);
	assign finish    = state == ST_CONVERT && conv_done_i && last_step;
	assign range_evt = state == ST_CONVERT && conv_done_i && auto_run
		&& (conv_data_i < thr_min || conv_data_i > thr_max);
	assign flag_rd  = reg_req_i.rd && reg_req_i.addr == SMS_AUTO_CTRL;
	assign auto_any = auto_cfg[SMS_TEMP_EN_BIT] || auto_cfg[SMS_AUX_EN_BIT];
	assign res_idx  = 4'(reg_req_i.addr - SMS_RESULT_BASE);
	// full address compare, so higher pages do not alias the results
	assign res_rd   = reg_req_i.rd && reg_req_i.addr >= SMS_RESULT_BASE
		&& reg_req_i.addr < SMS_RESULT_BASE + 8'(SMS_NSRC);

	always_comb begin
		next_written = written;
		if (state == ST_CONVERT && conv_done_i) begin
			next_written[cur_src] = 1'b1;
		end
	end

	// ****************************************
	// timers
	// ****************************************
	sms_timer #(.W(16)) u_step_tmr (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.load_i   (tmr_load),
		.count_i  (tmr_count),
		.busy_o   (),
		.expire_o (tmr_expire)
	);

	// interval runs back to back while any auto monitor is enabled
	sms_timer #(.W(IVL_W)) u_ivl_tmr (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.load_i   (auto_any && !ivl_busy),
		.count_i  (IVL_W'((auto_cfg[SMS_IVL_LSB +: 8] + 9'd1) * TICK_CYC)),
		.busy_o   (ivl_busy),
		.expire_o (ivl_expire)
	);

	// pulse timing
	// a new event restarts the pulse, so overlapping events stretch it
	sms_timer #(.W(PULSE_W)) u_pulse_tmr (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.load_i   (range_evt && auto_cfg[SMS_PULSE_EN_BIT]),
		.count_i  (PULSE_W'(PULSE_CYC)),
		.busy_o   (pulse_busy),
		.expire_o ()
	);

	// ****************************************
	// register writes
	// ****************************************
	// scan select
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			conv_ctrl <= SMS_CONV_RST;
			touch_cfg <= SMS_CFG_RST;
			auto_cfg  <= SMS_AUTO_RST;
			thr_min   <= SMS_MIN_RST;
			thr_max   <= SMS_MAX_RST;
		end else if (reg_req_i.wr) begin
			unique case (reg_req_i.addr)
				SMS_CONV_CTRL: conv_ctrl <= reg_req_i.wdata;
				SMS_TOUCH_CFG: touch_cfg <= reg_req_i.wdata;
				// the flag bit is not writable
				SMS_AUTO_CTRL: auto_cfg <= reg_req_i.wdata & ~(16'h1 << SMS_RANGE_BIT);
				SMS_THR_MIN: thr_min <= reg_req_i.wdata[11:0];
				SMS_THR_MAX: thr_max <= reg_req_i.wdata[11:0];
				default: ;
			endcase
		end
	end

	// host driver steps
	// driver-only codes just hold the panel drivers until the next write
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			hold_x <= 1'b0;
			hold_y <= 1'b0;
		end else if (conv_wr) begin
			hold_x <= wr_scan == SCAN_DRV_X;
			hold_y <= wr_scan == SCAN_DRV_Y;
		end
	end

	// start requests; a write in the take cycle wins
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			start_pend <= 1'b0;
			auto_pend  <= 1'b0;
		end else begin
			if (legal) begin
				start_pend <= 1'b1;
			end else if (state == ST_IDLE) begin
				start_pend <= 1'b0;
			end
			if (ivl_expire && auto_any) begin
				auto_pend <= 1'b1;
			end else if (!auto_any || (state == ST_IDLE && !start_pend && host_mode)) begin
				auto_pend <= 1'b0;
			end
		end
	end

	// ****************************************
	// sequence control
	// ****************************************
	always_comb begin
		next_state = state;
		tmr_load   = 1'b0;
		tmr_count  = 16'd1;
		unique case (state)
			ST_IDLE: begin
				if (start_pend || (auto_pend && host_mode)) begin
					next_state = ST_SETTLE;
					tmr_load   = 1'b1;
					if (start_pend && is_touch(sms_scan_t'(conv_ctrl[SMS_SCAN_LSB +: 4]))
						&& conv_ctrl[SMS_SCAN_LSB +: 4] inside {SCAN_XY, SCAN_XYZ}) begin
						tmr_count = 16'(SMS_SETTLE_CYC);
					end
				end
			end
			ST_SETTLE: begin
				if (tmr_expire) begin
					next_state = ST_SAMPLE;
					tmr_load   = 1'b1;
					tmr_count  = 16'(SMS_SAMPLE_CYC);
				end
			end
			ST_SAMPLE: begin
				if (tmr_expire) begin
					next_state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (conv_done_i) begin
					if (!last_step || (op == SCAN_AUX_CONT && !start_pend
						&& conv_ctrl[SMS_SCAN_LSB +: 4] == SCAN_AUX_CONT)) begin
						next_state = ST_SETTLE;
						tmr_load   = 1'b1;
						if (op inside {SCAN_XY, SCAN_XYZ}) begin
							tmr_count = 16'(SMS_SETTLE_CYC);
						end
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state     <= ST_IDLE;
			op        <= SCAN_NONE;
			idx       <= 2'd0;
			auto_run  <= 1'b0;
			auto_turn <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && start_pend) begin
				op       <= sms_scan_t'(conv_ctrl[SMS_SCAN_LSB +: 4]);
				idx      <= 2'd0;
				auto_run <= 1'b0;
			end else if (state == ST_IDLE && auto_pend && host_mode) begin
				// both monitors enabled: alternate between them
				idx       <= 2'd0;
				auto_run  <= 1'b1;
				auto_turn <= !auto_turn;
				if (auto_cfg[SMS_TEMP_EN_BIT] && (!auto_cfg[SMS_AUX_EN_BIT] || !auto_turn)) begin
					op <= SCAN_TEMP;
				end else begin
					op <= SCAN_AUX_INPUT_ONE;
				end
			end else if (state == ST_CONVERT && conv_done_i) begin
				idx <= last_step ? 2'd0 : idx + 2'd1;
			end
		end
	end

	// ****************************************
	// results
	// ****************************************
	// both temperatures
	// commit at end
	// results only change when the whole set is done
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			written <= '0;
			for (int i = 0; i < SMS_NSRC; i++) begin
				stage[i]   <= 12'h000;
				results[i] <= 12'h000;
			end
		end else begin
			if (state == ST_CONVERT && conv_done_i) begin
				stage[cur_src] <= conv_data_i;
				written        <= finish ? '0 : next_written;
			end
			for (int i = 0; i < SMS_NSRC; i++) begin
				if (finish && next_written[i]) begin
					results[i] <= (4'(i) == cur_src) ? conv_data_i : stage[i];
				end
			end
		end
	end

	// ****************************************
	// flag and pen line
	// ****************************************
	// read clears flag
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			range_flag <= 1'b0;
		end else if (range_evt) begin
			range_flag <= 1'b1;
		end else if (flag_rd) begin
			range_flag <= 1'b0;
		end
	end

	// touch comes from the panel comparator, asynchronous to the clock
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			touch_m <= 1'b0;
			touch_s <= 1'b0;
			touch_q <= 1'b0;
		end else begin
			touch_m <= touch_detect_i;
			touch_s <= touch_m;
			touch_q <= touch_s;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			both_low <= 1'b0;
			unread   <= '0;
		end else begin
			if (touch_s && !touch_q) begin
				both_low <= 1'b1;
			end else if (finish) begin
				both_low <= 1'b0;
			end
			if (finish) begin
				unread <= next_written;
			end else if (res_rd) begin
				unread[res_idx] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pen_data_ready_line_n_o <= 1'b1;
		end else begin
			unique case (touch_cfg[SMS_PEN_LSB +: 2])
				2'b00: pen_data_ready_line_n_o <= !touch_s;
				2'b01: pen_data_ready_line_n_o <= !(|unread);
				default: pen_data_ready_line_n_o <= !both_low;
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// base current
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			drive_o           <= '0;
			conv_start_o      <= 1'b0;
			conv_sel_o        <= SRC_X;
			general_pin_one_o <= 1'b0;
		end else begin
			drive_o.x_drv <= hold_x || (state != ST_IDLE
				&& cur_src inside {SRC_X, SRC_Z1, SRC_Z2} && is_touch(op));
			drive_o.y_drv <= hold_y || (state != ST_IDLE
				&& cur_src inside {SRC_Y, SRC_Z1, SRC_Z2} && is_touch(op));
			// led by next state so the divider drops as the conversion starts
			drive_o.bat_div   <= next_state == ST_SAMPLE && cur_src == SRC_BAT;
			drive_o.temp_hi   <= state != ST_IDLE && cur_src == SRC_TEMP_RAISED_CURRENT_RESULT;
			drive_o.res_int   <= state != ST_IDLE && op == SCAN_RES_INT;
			drive_o.res_ext   <= state != ST_IDLE && op == SCAN_RES_EXT;
			conv_start_o      <= state == ST_SAMPLE && tmr_expire;
			conv_sel_o        <= cur_src;
			general_pin_one_o <= pulse_busy;
		end
	end

	// register read data, one cycle after the read strobe
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				SMS_CONV_CTRL: reg_rdata_o <= conv_ctrl;
				SMS_TOUCH_CFG: reg_rdata_o <= touch_cfg;
				SMS_AUTO_CTRL: reg_rdata_o <= auto_cfg | (16'(range_flag) << SMS_RANGE_BIT);
				SMS_THR_MIN: reg_rdata_o <= {4'h0, thr_min};
				SMS_THR_MAX: reg_rdata_o <= {4'h0, thr_max};
				default: reg_rdata_o <= res_rd ? {4'h0, results[res_idx]} : 16'h0000;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	divider_window_a: assert property (
		drive_o.bat_div == (state == ST_SAMPLE && cur_src == SRC_BAT))
		else $error("battery divider not tied to sampling");
	host_only_a: assert property (
		conv_start_o && conv_sel_o inside {SRC_BAT, SRC_TEMP_BASE_CURRENT_RESULT, SRC_TEMP_RAISED_CURRENT_RESULT} |-> host_mode)
		else $error("nontouch conversion outside host mode");
	raised_current_a: assert property (
		conv_start_o && conv_sel_o == SRC_TEMP_RAISED_CURRENT_RESULT |-> drive_o.temp_hi)
		else $error("second temperature without raised current");
	flag_set_a: assert property (
		range_evt |=> range_flag)
		else $error("out of range event did not set flag");
	flag_keep_a: assert property (
		range_evt && flag_rd |=> range_flag ##1 (range_flag || flag_rd))
		else $error("flag lost on read collision");
	pulse_start_a: assert property (
		range_evt && auto_cfg[SMS_PULSE_EN_BIT] |-> ##2 general_pin_one_o [*2])
		else $error("pin one pulse missing");
	start_once_a: assert property (
		conv_start_o |=> !conv_start_o ##1 !conv_start_o)
		else $error("converter start longer than one cycle");
	pen_touch_a: assert property (
		touch_cfg[SMS_PEN_LSB +: 2] == 2'b00 && touch_s |=> !pen_data_ready_line_n_o)
		else $error("pen line not low on touch");
	port_commit_a: assert property (
		finish && op == SCAN_PORT |=> results[SRC_BAT] == $past(stage[SRC_BAT]))
		else $error("port scan battery result not committed");
	auto_source_a: assert property (
		conv_start_o && auto_run |-> conv_sel_o inside {SRC_TEMP_BASE_CURRENT_RESULT, SRC_AUX_INPUT_ONE})
		else $error("auto run converted wrong input");
endmodule

//--- sim/sms_sar_model.sv
// sar converter stand-in: answers each start with one done pulse
// assumes start and select come from the sequencer on the same clock
`timescale 1ns/1ns
module sms_sar_model
	import sms_pkg::*;
#(
	parameter int LAT = 8
) (
	input  wire logic     clock_i,
	input  wire logic     rst_i,
	input  wire logic     conv_start_i,
	input  wire sms_src_t conv_sel_i,
	output logic          conv_done_o,
	output logic [11:0]   conv_data_o
);
	int          wait_cnt;
	logic [11:0] held;

	// done comes LAT cycles after start, data is 12'h100 plus the source index;
	// outside the done cycle the data is inverted so a late sample cannot match
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wait_cnt <= 0;
			conv_done_o <= 1'b0;
			held <= 12'h000;
			conv_data_o <= 12'hfff;
		end else begin
			conv_done_o <= 1'b0;
			conv_data_o <= ~held;
			if (conv_start_i) begin
				wait_cnt <= LAT;
				held <= 12'h100 + {8'h00, conv_sel_i};
			end else if (wait_cnt == 1) begin
				wait_cnt <= 0;
				conv_done_o <= 1'b1;
				conv_data_o <= held;
			end else if (wait_cnt > 1) begin
				wait_cnt <= wait_cnt - 1;
			end
		end
	end
endmodule

//--- sim/test_sms_sequencer.sv
// self-checking bench for the measurement sequencer
// assumes the sar stand-in in sms_sar_model.sv; inputs change on falling edges
`timescale 1ns/1ns
module test_sms_sequencer;
	import sms_pkg::*;
	logic         clock_i;
	logic         rst_i;
	sms_reg_req_t req;
	logic [15:0]  rdata;
	logic         touch;
	logic         start;
	sms_src_t     sel;
	logic         done;
	logic [11:0]  cdata;
	sms_drive_t   drv;
	logic         pen_n;
	logic         pin1;
	int           err_total;
	int           cmp_count;
	int           starts;

	sms_sequencer #(.PULSE_CYC(20), .TICK_CYC(4)) dut (.clock_i(clock_i), .rst_i(rst_i),
		.reg_req_i(req), .reg_rdata_o(rdata), .touch_detect_i(touch), .conv_start_o(start),
		.conv_sel_o(sel), .conv_done_i(done), .conv_data_i(cdata), .drive_o(drv),
		.pen_data_ready_line_n_o(pen_n), .general_pin_one_o(pin1));
	sms_sar_model sar (.clock_i(clock_i), .rst_i(rst_i), .conv_start_i(start),
		.conv_sel_i(sel), .conv_done_o(done), .conv_data_o(cdata));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write or read pulse, launched on a falling edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clock_i) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clock_i) req <= '0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clock_i) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge clock_i) req <= '0;
		@(negedge clock_i) chk(rdata, exp);
	endtask

	// bounded wait until the converter has been started n more times
	task automatic wait_starts(input int n);
		int goal;
		goal = starts + n;
		for (int i = 0; i < 6000 * n && starts < goal; i++) @(negedge clock_i);
		chk(16'(starts), 16'(goal));
		repeat (20) @(negedge clock_i);
	endtask

	// counts starts and watches driver levels at every start
	always @(posedge clock_i) begin
		if (!rst_i && start) begin
			starts++;
			if (drv.bat_div !== 1'b0) chk(16'h0001, 16'h0000);
			chk(16'(drv.temp_hi), 16'(sel == SRC_TEMP_RAISED_CURRENT_RESULT));
			if (sel == SRC_X) chk(16'(drv.x_drv), 16'h0001);
		end
		if (!rst_i && drv.bat_div && sel !== SRC_BAT) chk(16'h0001, 16'h0000);
	end

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_regs();
		rd_chk(SMS_CONV_CTRL, SMS_CONV_RST);
		rd_chk(SMS_TOUCH_CFG, SMS_CFG_RST);
		rd_chk(SMS_AUTO_CTRL, SMS_AUTO_RST);
		rd_chk(SMS_THR_MIN, 16'(SMS_MIN_RST));
		rd_chk(SMS_THR_MAX, 16'(SMS_MAX_RST));
		rd_chk(8'h3f, 16'h0000);
	endtask

	// self-controlled mode refuses battery, temperature and port scans
	task automatic t_self_refuse();
		int         s0;
		logic [3:0] codes [3];
		codes = '{4'h5, 4'h9, 4'hb};
		s0 = starts;
		for (int i = 0; i < 3; i++) begin
			wr(SMS_CONV_CTRL, 16'(codes[i]) << SMS_SCAN_LSB);
			repeat (1200) @(negedge clock_i);
		end
		chk(16'(starts), 16'(s0));
		wr(SMS_CONV_CTRL, 16'h0000);
	endtask

	// touch pulls the pen line low and starts nothing by itself
	task automatic t_touch();
		int s0;
		s0 = starts;
		wr(SMS_TOUCH_CFG, 16'h0001 << SMS_MODE_BIT);
		@(negedge clock_i) touch = 1'b1;
		repeat (5) @(negedge clock_i);
		chk(16'(pen_n), 16'h0000);
		repeat (200) @(negedge clock_i);
		chk(16'(starts), 16'(s0));
		touch = 1'b0;
		repeat (5) @(negedge clock_i);
		chk(16'(pen_n), 16'h0001);
	endtask

	// stepwise host control: x drivers first, settle, then one x conversion
	task automatic t_steps();
		wr(SMS_CONV_CTRL, 16'(SCAN_DRV_X) << SMS_SCAN_LSB);
		repeat (SMS_SETTLE_CYC) @(negedge clock_i);
		chk(16'(drv.x_drv), 16'h0001);
		wr(SMS_CONV_CTRL, 16'(SCAN_X) << SMS_SCAN_LSB);
		wait_starts(1);
		rd_chk(SMS_RESULT_BASE, 16'h0100);
	endtask

	// port scan then differential temperature, results read back;
	// pen line as data ready stays low until the whole set is read
	task automatic t_scans();
		wr(SMS_TOUCH_CFG, 16'h5000);
		wr(SMS_CONV_CTRL, 16'(SCAN_PORT) << SMS_SCAN_LSB);
		wait_starts(3);
		chk(16'(pen_n), 16'h0000);
		for (int i = 0; i < 3; i++)
			rd_chk(SMS_RESULT_BASE + 8'(4 + i), 16'h0104 + 16'(i));
		chk(16'(pen_n), 16'h0001);
		rd_chk(8'h24, 16'h0000);
		wr(SMS_CONV_CTRL, 16'(SCAN_TDIFF) << SMS_SCAN_LSB);
		wait_starts(2);
		rd_chk(SMS_RESULT_BASE + 8'h07, 16'h0107);
		rd_chk(SMS_RESULT_BASE + 8'h08, 16'h0108);
		wr(SMS_CONV_CTRL, 16'h0000);
	endtask

	// auto temperature below min: flag, pulse of 20 cycles, clear on read
	task automatic t_auto_range();
		int hi;
		hi = 0;
		wr(SMS_THR_MIN, 16'h0200);
		wr(SMS_THR_MAX, 16'h0300);
		wr(SMS_AUTO_CTRL, 16'h8200);
		for (int i = 0; i < 5000 && !pin1; i++) @(negedge clock_i);
		while (pin1 === 1'b1 && hi < 100) begin
			hi++;
			@(negedge clock_i);
		end
		chk(16'(hi), 16'd20);
		// the result is taken ten edges after the start pulse seen here,
		// so this read of the flag meets an out of range event
		for (int i = 0; i < 200 && start !== 1'b1; i++) @(negedge clock_i);
		repeat (9) @(negedge clock_i);
		req <= '{wr: 1'b0, rd: 1'b1, addr: SMS_AUTO_CTRL, wdata: 16'h0000};
		@(negedge clock_i) req <= '0;
		chk(rdata, 16'ha200);
		// later results fall inside the range, so only the kept event shows
		wr(SMS_THR_MIN, 16'h0000);
		wr(SMS_AUTO_CTRL, 16'h0200);
		repeat (1200) @(negedge clock_i);
		rd_chk(SMS_AUTO_CTRL, 16'h2200);
		rd_chk(SMS_AUTO_CTRL, 16'h0200);
	endtask

	task automatic summarize();
		if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// clock, reset, sequence, watchdog
	// ****************************************
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	initial begin
		err_total = 0;
		cmp_count = 0;
		starts = 0;
		rst_i = 1'b1;
		req = '0;
		touch = 1'b0;
		repeat (4) @(negedge clock_i);
		rst_i = 1'b0;
		t_reset_regs();
		t_self_refuse();
		t_touch();
		t_steps();
		t_scans();
		t_auto_range();
		summarize();
	end

	// whole run needs about 7k cycles; cut off well past that
	initial begin
		#200000;
		err_total++;
		summarize();
	end
endmodule
